//--- hw/disk_ctl.sv
`timescale 1ns/1ps
module disk_ctl
  import disk_ctl_pkg::*;
(
  input  wire logic              mclk_i,
  input  wire logic              rst_i,
  // AXI4-Lite slave
  input  wire logic [AXI_AW-1:0] s_axi_awaddr_i,
  input  wire logic              s_axi_awvalid_i,
  output logic                   s_axi_awready_o,
  input  wire logic [31:0]       s_axi_wdata_i,
  input  wire logic [3:0]        s_axi_wstrb_i,
  input  wire logic              s_axi_wvalid_i,
  output logic                   s_axi_wready_o,
  output logic [1:0]             s_axi_bresp_o,
  output logic                   s_axi_bvalid_o,
  input  wire logic              s_axi_bready_i,
  input  wire logic [AXI_AW-1:0] s_axi_araddr_i,
  input  wire logic              s_axi_arvalid_i,
  output logic                   s_axi_arready_o,
  output logic [31:0]            s_axi_rdata_o,
  output logic [1:0]             s_axi_rresp_o,
  output logic                   s_axi_rvalid_o,
  input  wire logic              s_axi_rready_i,
  // Data path events, same clock
  input  wire logic              xfer_sector_done_i,
  input  wire logic              xfer_words_done_i,
  input  wire logic              data_crc_error_i,
  input  wire logic              header_crc_error_i,
  input  wire logic              write_check_error_i,
  input  wire logic              data_late_i,
  input  wire logic              header_not_found_i,
  input  wire logic              nonexistent_memory_i,
  // Drive bus
  input  wire logic [15:0]       drive_status_i,
  output logic                   drive_reset_o,
  output logic                   xfer_start_o,
  output logic                   xfer_active_o,
  output logic [2:0]             xfer_fn_o,
  output logic [15:0]            disk_address_o,
  output logic [8:0]             position_cylinder_o,
  output logic                   position_head_o,
  output logic                   irq_o
);

  typedef enum logic [1:0] {
    CTL_IDLE = 2'h1,
    CTL_XFER = 2'h2
  } ctl_state_t;

  typedef struct packed {
    logic              awready;
    logic              wready;
    logic              aw_held;
    logic              w_held;
    logic [AXI_AW-1:0] awaddr;
    logic [31:0]       wdata;
    logic [3:0]        wstrb;
    logic              bvalid;
    logic [1:0]        bresp;
    logic              arready;
    logic              rvalid;
    logic [1:0]        rresp;
    logic [31:0]       rdata;
    ctl_state_t        state;
    logic              interrupt_enable;
    logic              controller_ready;
    logic [2:0]        fn;
    logic [4:0]        err;
    logic [15:0]       disk_address;
    logic [15:0]       dstat;
    logic [IRQ_W-1:0]  istat;
    logic [IRQ_W-1:0]  imask;
    logic [15:0]       ds_s1;
    logic [15:0]       ds_s2;
    logic              xfer_start;
    logic              xfer_active;
    logic              drive_reset;
    logic              seek_go;
    logic              irq;
  } ctl_t;

  ctl_t             s;
  ctl_t             next_s;
  logic             start;
  logic             fin;
  logic [4:0]       errset;
  logic [IRQ_W-1:0] iset;
  logic [IRQ_W-1:0] iclr;
  logic [15:0]      wd;
  logic             pos_ready;

  // Byte-lane merge of a 16-bit register
  function automatic logic [15:0] merge16(input logic [15:0] old, input logic [31:0] data,
                                          input logic [3:0] strb);
    merge16 = old;
    if (strb[0]) merge16[7:0] = data[7:0];
    if (strb[1]) merge16[15:8] = data[15:8];
  endfunction : merge16

  // Address decode shared by read and write
  function automatic logic [2:0] reg_index(input logic [AXI_AW-1:0] a);
    case (a)
      OFS_CSR:   reg_index = IDX_CSR;
      OFS_DA:    reg_index = IDX_DA;
      OFS_DSTAT: reg_index = IDX_DSTAT;
      OFS_ISTAT: reg_index = IDX_ISTAT;
      OFS_IMASK: reg_index = IDX_IMASK;
      default:   reg_index = IDX_NONE;
    endcase
  endfunction : reg_index

  // Control/status word as software sees it
  function automatic logic [15:0] csr_word(input ctl_t c, input logic drdy);
    csr_word                        = '0;
    csr_word[CSR_DRDY]              = drdy;
    csr_word[CSR_FN_HI:CSR_FN_LO]   = c.fn;
    csr_word[CSR_IE]                = c.interrupt_enable;
    csr_word[CSR_CONTROLLER_READY]              = c.controller_ready;
    csr_word[CSR_ERR_HI:CSR_ERR_LO] = c.err;
    csr_word[CSR_ANY_ERR]           = |c.err;
  endfunction : csr_word

  seek_positioner u_pos (
    .mclk_i     (mclk_i),
    .rst_i      (rst_i),
    .go_i       (s.seek_go),
    .dir_i      (s.disk_address[SK_DIR]),
    .head_i     (s.disk_address[SK_HEAD]),
    .diff_i     (s.disk_address[SK_DIFF_HI:SK_DIFF_LO]),
    .ready_o    (pos_ready),
    .cylinder_o (position_cylinder_o),
    .head_o     (position_head_o)
  );

  assign s_axi_awready_o = s.awready;
  assign s_axi_wready_o  = s.wready;
  assign s_axi_bvalid_o  = s.bvalid;
  assign s_axi_bresp_o   = s.bresp;
  assign s_axi_arready_o = s.arready;
  assign s_axi_rvalid_o  = s.rvalid;
  assign s_axi_rdata_o   = s.rdata;
  assign s_axi_rresp_o   = s.rresp;
  assign drive_reset_o   = s.drive_reset;
  assign xfer_start_o    = s.xfer_start;
  assign xfer_active_o   = s.xfer_active;
  assign xfer_fn_o       = s.fn;
  assign disk_address_o  = s.disk_address;
  assign irq_o           = s.irq;

  // Whole next-state computation
  always_comb begin
    next_s = s;
    start  = 1'b0;
    fin    = 1'b0;
    errset = '0;
    iset   = '0;
    iclr   = '0;
    wd     = '0;

    // Drive status pins cross in through two flops
    next_s.ds_s1       = drive_status_i;
    next_s.ds_s2       = s.ds_s1;
    next_s.xfer_start  = 1'b0;
    next_s.drive_reset = 1'b0;
    next_s.seek_go     = 1'b0;

    // Write address and data, taken in either order
    if (s.awready && s_axi_awvalid_i) begin
      next_s.aw_held = 1'b1;
      next_s.awaddr  = s_axi_awaddr_i;
    end
    if (s.wready && s_axi_wvalid_i) begin
      next_s.w_held = 1'b1;
      next_s.wdata  = s_axi_wdata_i;
      next_s.wstrb  = s_axi_wstrb_i;
    end
    if (s.bvalid && s_axi_bready_i) begin
      next_s.bvalid = 1'b0;
    end

    // Register write once both halves are held
    if (s.aw_held && s.w_held && !s.bvalid) begin
      next_s.aw_held = 1'b0;
      next_s.w_held  = 1'b0;
      next_s.bvalid  = 1'b1;
      next_s.bresp   = RESP_OKAY;
      case (reg_index(s.awaddr))
        IDX_CSR: begin
          wd                      = merge16(csr_word(s, pos_ready), s.wdata, s.wstrb);
          next_s.interrupt_enable = wd[CSR_IE];
          // Clearing ready starts a function; ignored while busy
          if (s.controller_ready) begin
            next_s.fn = wd[CSR_FN_HI:CSR_FN_LO];
            start     = !wd[CSR_CONTROLLER_READY];
          end
        end
        IDX_DA: begin
          if (s.controller_ready) begin
            next_s.disk_address = merge16(s.disk_address, s.wdata, s.wstrb);
          end
        end
        IDX_DSTAT: begin
          next_s.bresp = RESP_OKAY;
        end
        IDX_ISTAT: begin
          iclr = s.wdata[IRQ_W-1:0] & {IRQ_W{s.wstrb[0]}};
        end
        IDX_IMASK: begin
          if (s.wstrb[0]) begin
            next_s.imask = s.wdata[IRQ_W-1:0];
          end
        end
        default: next_s.bresp = RESP_SLVERR;
      endcase
    end
    // Hold off new writes until the response is taken
    next_s.awready = !next_s.aw_held && !next_s.bvalid;
    next_s.wready  = !next_s.w_held && !next_s.bvalid;

    // Read channel, one outstanding
    if (s.rvalid && s_axi_rready_i) begin
      next_s.rvalid  = 1'b0;
      next_s.arready = 1'b1;
    end
    if (s.arready && s_axi_arvalid_i) begin
      next_s.arready = 1'b0;
      next_s.rvalid  = 1'b1;
      next_s.rresp   = RESP_OKAY;
      next_s.rdata   = '0;
      case (reg_index(s_axi_araddr_i))
        IDX_CSR:   next_s.rdata[15:0]      = csr_word(s, pos_ready);
        IDX_DA:    next_s.rdata[15:0]      = s.disk_address;
        IDX_DSTAT: next_s.rdata[15:0]      = s.dstat;
        IDX_ISTAT: next_s.rdata[IRQ_W-1:0] = s.istat;
        IDX_IMASK: next_s.rdata[IRQ_W-1:0] = s.imask;
        default:   next_s.rresp            = RESP_SLVERR;
      endcase
    end

    // Function dispatch
    if (start) begin
      case (next_s.fn)
        FN_RESET: begin
          next_s.drive_reset = 1'b1;
          fin                = 1'b1;
        end
        FN_STATUS: begin
          // Snapshot of the drive word with its error bits
          next_s.dstat = s.ds_s2;
          fin          = 1'b1;
        end
        FN_SEEK: begin
          // Ready stays set; only the issue is signalled, not the end
          next_s.seek_go = pos_ready;
          iset[IRQ_SEEK] = 1'b1;
        end
        FN_WRITE, FN_READ, FN_READ_RAW: begin
          next_s.controller_ready = 1'b0;
          next_s.state            = CTL_XFER;
          next_s.xfer_start       = 1'b1;
        end
        default: fin = 1'b1;
      endcase
    end

    // Transfer error encoding, bit 10 marks the header variants
    if (s.state == CTL_XFER) begin
      errset[ERR_INCOMPLETE] = header_crc_error_i | header_not_found_i;
      errset[ERR_CRC]        = data_crc_error_i | write_check_error_i | header_crc_error_i;
      errset[ERR_LATE]       = data_late_i | header_not_found_i;
      errset[ERR_MEMORY]     = nonexistent_memory_i;
      // No spiral transfer: running off the track stops it
      if (xfer_sector_done_i && s.fn != FN_READ_RAW) begin
        if (s.disk_address[DA_SEC_HI:DA_SEC_LO] == SECTOR_LAST) begin
          next_s.disk_address[DA_SEC_HI:DA_SEC_LO] = SECTOR_OVER;
          errset[ERR_INCOMPLETE]                   = 1'b1;
        end else begin
          next_s.disk_address[DA_SEC_HI:DA_SEC_LO] = s.disk_address[DA_SEC_HI:DA_SEC_LO] + SECTOR_ONE;
        end
      end
      fin = fin | xfer_words_done_i;
    end
    // Drive error is a level, but the flag is sticky and only clears at the next function start
    errset[ERR_DRIVE] = |(s.ds_s2 & DS_ERR_MASK);

    // Flags clear at start; a same-cycle set still wins
    next_s.err = (start ? 5'h00 : s.err) | errset;

    // Completion or any error brings ready back
    if (fin || (|errset)) begin
      next_s.controller_ready = 1'b1;
      next_s.state            = CTL_IDLE;
      next_s.xfer_start       = 1'b0;
    end
    iset[IRQ_DONE]  = fin;
    iset[IRQ_ERR]   = |(errset & ~s.err);
    iset[IRQ_READY] = s.interrupt_enable & s.controller_ready;

    // Sticky status, set wins over write-one clear
    next_s.istat       = (s.istat & ~iclr) | iset;
    next_s.irq         = |(next_s.istat & next_s.imask);
    next_s.xfer_active = (next_s.state == CTL_XFER);
  end

  // State register
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      s                  <= '0;
      s.state            <= CTL_IDLE;
      s.controller_ready <= 1'b1;
      s.awready          <= 1'b1;
      s.wready           <= 1'b1;
      s.arready          <= 1'b1;
    end else begin
      s <= next_s;
    end
  end

  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (rst_i);

  a_header_crc_bits: assert property (
    (s.state == CTL_XFER && header_crc_error_i)
    |=> (s.err[ERR_CRC] && s.err[ERR_INCOMPLETE] && s.controller_ready))
    else $error("header CRC not shown as bits 11 and 10");

  a_late_plain: assert property (
    (s.state == CTL_XFER && data_late_i && !header_not_found_i && !header_crc_error_i && !xfer_sector_done_i)
    |=> (s.err[ERR_LATE] && !s.err[ERR_INCOMPLETE]))
    else $error("data late not shown as bit 12 alone");

  a_hdr_missing_bits: assert property (
    (s.state == CTL_XFER && header_not_found_i)
    |=> (s.err[ERR_LATE] && s.err[ERR_INCOMPLETE] && s.state == CTL_IDLE))
    else $error("header not found not shown as bits 12 and 10");

  a_memory_bit: assert property (
    (s.state == CTL_XFER && nonexistent_memory_i) |=> (s.err[ERR_MEMORY] && s.controller_ready))
    else $error("memory error did not set bit 13 and ready");

  a_track_overrun: assert property (
    (s.state == CTL_XFER && xfer_sector_done_i && s.fn != FN_READ_RAW
     && s.disk_address[DA_SEC_HI:DA_SEC_LO] == SECTOR_LAST)
    |=> (s.disk_address[DA_SEC_HI:DA_SEC_LO] == SECTOR_OVER && s.err[ERR_INCOMPLETE] && !xfer_active_o))
    else $error("track overrun not flagged with sector 50 octal");

  a_drive_composite: assert property (
    (|(s.ds_s2 & DS_ERR_MASK)) |=> s.err[ERR_DRIVE] ##1 s.err[ERR_DRIVE] || !$past(|(s.ds_s2 & DS_ERR_MASK)))
    else $error("composite drive error missing");

  a_seek_issue_irq: assert property (
    $rose(s.seek_go) |-> (s.controller_ready && s.istat[IRQ_SEEK] && !xfer_active_o))
    else $error("seek issue did not signal at once");

  a_ready_irq: assert property (
    (s.interrupt_enable && s.controller_ready && s.imask[IRQ_READY]) |=> irq_o)
    else $error("interrupt missing with enable and ready set");

  a_write_answer: assert property (
    (s.aw_held && s.w_held && !s.bvalid) |=> (s_axi_bvalid_o && !s_axi_awready_o))
    else $error("write response not given one cycle after capture");

endmodule : disk_ctl

//--- hw/seek_positioner.sv
`timescale 1ns/1ps
module seek_positioner
  import disk_ctl_pkg::*;
(
  input  wire logic       mclk_i,
  input  wire logic       rst_i,
  input  wire logic       go_i,
  input  wire logic       dir_i,
  input  wire logic       head_i,
  input  wire logic [8:0] diff_i,
  output logic            ready_o,
  output logic [8:0]      cylinder_o,
  output logic            head_o
);

  typedef enum logic [2:0] {
    POS_IDLE   = 3'h1,
    POS_MOVE   = 3'h2,
    POS_SETTLE = 3'h4
  } pos_state_t;

  typedef struct packed {
    pos_state_t       ps;
    logic [8:0]       cyl;
    logic [8:0]       tgt;
    logic             head;
    logic [CNT_W-1:0] cnt;
    logic             ready;
  } pos_t;

  pos_t       s;
  pos_t       next_s;
  logic [9:0] sum;

  assign ready_o    = s.ready;
  assign cylinder_o = s.cyl;
  assign head_o     = s.head;

  // Target, stepping and settle
  always_comb begin
    next_s = s;
    sum    = {1'b0, s.cyl} + {1'b0, diff_i};
    case (s.ps)
      POS_IDLE: begin
        if (go_i) begin
          // Same-cylinder head switch still runs through settle
          next_s.head  = head_i;
          next_s.ready = 1'b0;
          next_s.cnt   = STEP_CYC;
          next_s.ps    = POS_MOVE;
          if (!dir_i) begin
            // Overshoot outward lands in guard band, retreat to zero
            next_s.tgt = (diff_i > s.cyl) ? 9'h000 : s.cyl - diff_i;
          end else if (sum > {1'b0, CYL_LAST}) begin
            next_s.tgt = CYL_LAST;
          end else begin
            next_s.tgt = sum[8:0];
          end
        end
      end
      POS_MOVE: begin
        if (s.cyl == s.tgt) begin
          next_s.cnt = SETTLE_CYC;
          next_s.ps  = POS_SETTLE;
        end else if (s.cnt == CNT_ONE) begin
          next_s.cnt = STEP_CYC;
          next_s.cyl = (s.tgt > s.cyl) ? s.cyl + 9'h001 : s.cyl - 9'h001;
        end else begin
          next_s.cnt = s.cnt - CNT_ONE;
        end
      end
      POS_SETTLE: begin
        // Centre of track reached when the settle count runs out
        if (s.cnt == CNT_ONE) begin
          next_s.ready = 1'b1;
          next_s.ps    = POS_IDLE;
        end else begin
          next_s.cnt = s.cnt - CNT_ONE;
        end
      end
      default: next_s.ps = POS_IDLE;
    endcase
  end

  // State register
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      s       <= '0;
      s.ps    <= POS_IDLE;
      s.ready <= 1'b1;
    end else begin
      s <= next_s;
    end
  end

  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (rst_i);

  a_guard_band_zero: assert property (
    (s.ps == POS_IDLE && go_i && !dir_i && diff_i > s.cyl) |=> (s.tgt == 9'h000 && !ready_o))
    else $error("outward overshoot did not target cylinder zero");

  a_settle_done: assert property (
    (s.ps == POS_SETTLE && s.cnt == CNT_ONE) |=> (ready_o && s.ps == POS_IDLE))
    else $error("positioner not ready after settle");

  a_busy_not_ready: assert property (
    (s.ps != POS_IDLE) |-> !ready_o)
    else $error("ready shown while heads still moving");

endmodule : seek_positioner

//--- pkg/disk_ctl_pkg.sv
package disk_ctl_pkg;

  // Register bus
  localparam int         AXI_AW      = 5;
  localparam logic [4:0] OFS_CSR     = 5'h00;
  localparam logic [4:0] OFS_DA      = 5'h04;
  localparam logic [4:0] OFS_DSTAT   = 5'h08;
  localparam logic [4:0] OFS_ISTAT   = 5'h0C;
  localparam logic [4:0] OFS_IMASK   = 5'h10;
  localparam logic [2:0] IDX_CSR     = 3'h0;
  localparam logic [2:0] IDX_DA      = 3'h1;
  localparam logic [2:0] IDX_DSTAT   = 3'h2;
  localparam logic [2:0] IDX_ISTAT   = 3'h3;
  localparam logic [2:0] IDX_IMASK   = 3'h4;
  localparam logic [2:0] IDX_NONE    = 3'h7;
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // Control/status word fields
  localparam int CSR_DRDY    = 0;
  localparam int CSR_FN_LO   = 1;
  localparam int CSR_FN_HI   = 3;
  localparam int CSR_IE      = 6;
  localparam int CSR_CONTROLLER_READY    = 7;
  localparam int CSR_ERR_LO  = 10;
  localparam int CSR_ERR_HI  = 14;
  localparam int CSR_ANY_ERR = 15;

  // Error vector, bit 0 is control/status bit 10
  localparam int ERR_INCOMPLETE = 0;
  localparam int ERR_CRC        = 1;
  localparam int ERR_LATE       = 2;
  localparam int ERR_MEMORY     = 3;
  localparam int ERR_DRIVE      = 4;

  // Drive status word error bits
  localparam int           DS_SELECT    = 8;
  localparam int           DS_WGATE     = 10;
  localparam int           DS_SPIN      = 11;
  localparam int           DS_SEEK_TO   = 12;
  localparam int           DS_HEAD_CUR  = 14;
  localparam int           DS_WDATA     = 15;
  localparam logic [15:0]  DS_ERR_MASK  = 16'hDD00;

  // Disk address, transfer layout and seek layout
  localparam int         DA_SEC_LO    = 0;
  localparam int         DA_SEC_HI    = 5;
  localparam int         SK_DIR       = 2;
  localparam int         SK_HEAD      = 4;
  localparam int         SK_DIFF_LO   = 7;
  localparam int         SK_DIFF_HI   = 15;
  localparam logic [5:0] SECTOR_LAST  = 6'h27;
  localparam logic [5:0] SECTOR_OVER  = 6'h28; // 50 octal, illegal
  localparam logic [5:0] SECTOR_ONE   = 6'h01;
  localparam logic [8:0] CYL_LAST     = 9'h0FF;

  // Function codes
  localparam logic [2:0] FN_MAINT     = 3'h0;
  localparam logic [2:0] FN_RESET     = 3'h1;
  localparam logic [2:0] FN_STATUS    = 3'h2;
  localparam logic [2:0] FN_SEEK      = 3'h3;
  localparam logic [2:0] FN_RDHDR     = 3'h4;
  localparam logic [2:0] FN_WRITE     = 3'h5;
  localparam logic [2:0] FN_READ      = 3'h6;
  localparam logic [2:0] FN_READ_RAW  = 3'h7;

  // Interrupt status bits
  localparam int IRQ_W     = 4;
  localparam int IRQ_READY = 0;
  localparam int IRQ_DONE  = 1;
  localparam int IRQ_SEEK  = 2;
  localparam int IRQ_ERR   = 3;

  // Positioner timing
  localparam int              CLK_PERIOD_PS = 5000;
  localparam int              STEP_NS       = 100;
  localparam int              SETTLE_NS     = 1000;
  localparam int              CNT_W         = 12;
  localparam logic [CNT_W-1:0] STEP_CYC     = CNT_W'((STEP_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS);
  localparam logic [CNT_W-1:0] SETTLE_CYC   = CNT_W'((SETTLE_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS);
  localparam logic [CNT_W-1:0] CNT_ONE      = 12'h001;

endpackage : disk_ctl_pkg

//--- testbench/disk_error_flag_and_seek_rules_tb_top.sv
`timescale 1ns/1ps
module disk_error_flag_and_seek_rules_tb_top;
  import disk_ctl_pkg::*;
  logic        mclk_i = 0, rst_i = 1, awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0, sdone = 0;
  logic [4:0]  awaddr = '0, araddr = '0;
  logic [31:0] wdata = '0, rdata, got;
  logic [6:0]  ev = '0;
  logic [5:0]  fault = '0;
  logic [7:0]  noise = '0;
  logic [15:0] dsw, da;
  logic        awr, wrd, bv, arr, rv, irq, head, drst, xst, act;
  logic [1:0]  rresp, bresp;
  logic [8:0]  cyl;
  logic [33:0] q[$], ex;
  logic [15:0] et [7] = '{16'h0800, 16'h0C00, 16'h0800, 16'h1000, 16'h1400, 16'h2000, 16'h0000};
  int          bad_count = 0, comparisons = 0, seed = 32'hf61f23be, i, resets = 0, starts = 0;
  always #2.5 mclk_i = ~mclk_i;
  drive_model drv (.mclk_i, .fault_i(fault), .noise_i(noise), .status_o(dsw));
  disk_ctl dut (.mclk_i, .rst_i, .s_axi_awaddr_i(awaddr), .s_axi_awvalid_i(awvalid), .s_axi_awready_o(awr),
    .s_axi_wdata_i(wdata), .s_axi_wstrb_i(4'h3), .s_axi_wvalid_i(wvalid), .s_axi_wready_o(wrd),
    .s_axi_bresp_o(bresp), .s_axi_bvalid_o(bv), .s_axi_bready_i(bready), .s_axi_araddr_i(araddr),
    .s_axi_arvalid_i(arvalid), .s_axi_arready_o(arr), .s_axi_rdata_o(rdata), .s_axi_rresp_o(rresp),
    .s_axi_rvalid_o(rv), .s_axi_rready_i(rready), .xfer_sector_done_i(sdone), .xfer_words_done_i(ev[6]),
    .data_crc_error_i(ev[0]), .header_crc_error_i(ev[1]), .write_check_error_i(ev[2]), .data_late_i(ev[3]),
    .header_not_found_i(ev[4]), .nonexistent_memory_i(ev[5]), .drive_status_i(dsw), .drive_reset_o(drst),
    .xfer_start_o(xst), .xfer_active_o(act), .xfer_fn_o(), .disk_address_o(da),
    .position_cylinder_o(cyl), .position_head_o(head), .irq_o(irq));
  task automatic test_done;
    $display("comparisons %0d bad_count %0d", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : test_done
  task automatic chk(input logic ok, input string m);
    comparisons++;
    if (ok !== 1'b1) begin
      bad_count++;
      $display("CHECK FAILED at %0t: %s", $time, m);
    end
  endtask : chk
  // Write: address and data offered together, each dropped once taken
  task automatic wr(input logic [4:0] a, input logic [15:0] d);
    int k;
    @(posedge mclk_i);
    awaddr  <= a;
    wdata   <= {16'h0000, d};
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    bready  <= 1'b1;
    for (k = 0; k < 50; k++) begin
      @(posedge mclk_i);
      if (awvalid && awr) awvalid <= 1'b0;
      if (wvalid && wrd) wvalid <= 1'b0;
      if (bv) break;
    end
    bready <= 1'b0;
    if (k == 50) begin
      chk(1'b0, "write hang");
      test_done();
    end
    chk(bresp === RESP_OKAY, "write response");
  endtask : wr
  // Read: expectation queued first unless only polling
  task automatic rd(input logic [4:0] a, input logic [33:0] e, input logic keep);
    int k;
    if (keep) q.push_back(e);
    @(posedge mclk_i);
    araddr  <= a;
    arvalid <= 1'b1;
    rready  <= 1'b1;
    for (k = 0; k < 50; k++) begin
      @(posedge mclk_i);
      if (arvalid && arr) arvalid <= 1'b0;
      if (rv) break;
    end
    got = rdata;
    rready <= 1'b0;
    if (k == 50) begin
      chk(1'b0, "read hang");
      test_done();
    end
  endtask : rd
  // Seek end is only visible by polling drive ready
  task automatic poll;
    int k;
    for (k = 0; k < 200; k++) begin
      rd(OFS_CSR, '0, 1'b0);
      if (got[0]) break;
    end
    if (k == 200) begin
      chk(1'b0, "seek hang");
      test_done();
    end
  endtask : poll
  // Result side: oldest expectation against each read answer
  always @(posedge mclk_i) begin
    if (rv && rready && q.size() > 0) begin
      ex = q.pop_front();
      chk({rresp, rdata} === ex, "read value");
    end
  end
  // One-cycle pulses counted while they stand
  always @(posedge mclk_i) begin
    if (drst === 1'b1) resets++;
    if (xst === 1'b1) starts++;
  end
  initial begin
    repeat (4) @(posedge mclk_i);
    rst_i <= 1'b0;
    rd(OFS_CSR, 34'h0081, 1);
    // Each data path error in a read, then a clean finish
    for (i = 0; i < 7; i++) begin
      wr(OFS_CSR, 16'h000C);
      chk(act === 1'b1, "transfer not running");
      @(posedge mclk_i);
      ev <= 7'(1 << i);
      @(posedge mclk_i);
      ev <= '0;
      rd(OFS_CSR, {18'h0, et[i] != 0, et[i][14:0] | 15'h008D}, 1);
    end
    // From sector 38: one advance, then the overrun
    wr(OFS_DA, 16'h0026);
    wr(OFS_CSR, 16'h000A);
    repeat (2) begin
      @(posedge mclk_i);
      sdone <= 1'b1;
      @(posedge mclk_i);
      sdone <= 1'b0;
    end
    rd(OFS_DA, 34'h0028, 1);
    rd(OFS_CSR, 34'h848B, 1);
    chk(act === 1'b0, "overrun left transfer running");
    wr(OFS_IMASK, 16'h0005);
    wr(OFS_CSR, 16'h00C0);
    repeat (2) @(posedge mclk_i);
    chk(irq === 1'b1, "ready irq");
    wr(OFS_CSR, 16'h0080);
    wr(OFS_ISTAT, 16'h0001);
    wr(OFS_DA, 16'h0184);
    wr(OFS_CSR, 16'h0006);
    repeat (2) @(posedge mclk_i);
    chk(irq === 1'b1, "seek irq");
    wr(OFS_ISTAT, 16'h0004);
    poll();
    chk(cyl === 9'h003 && irq === 1'b0, "inward seek");
    wr(OFS_DA, 16'h0290);
    wr(OFS_CSR, 16'h0006);
    poll();
    chk(cyl === 9'h000 && head === 1'b1, "guard band");
    // Each drive fault alone, fetched by get-status
    for (i = 0; i < 6; i++) begin
      noise <= 8'($random(seed));
      fault <= 6'(1 << i);
      repeat (4) @(posedge mclk_i);
      wr(OFS_CSR, 16'h0004);
      rd(OFS_DSTAT, {18'h0, dsw}, 1);
      rd(OFS_CSR, 34'hC085, 1);
      fault <= '0; // Faults 14, 15 never retried, timeout waits on reset
      @(posedge mclk_i);
    end
    // Drive reset function, as issued after a seek timeout
    wr(OFS_CSR, 16'h0002);
    rd(OFS_CSR, 34'h0083, 1);
    rd(5'h14, {RESP_SLVERR, 32'h0}, 1);
    repeat (2) @(posedge mclk_i);
    chk(q.size() == 0, "reads missing");
    chk(resets == 1 && starts == 8, "function pulse count");
    test_done();
  end
endmodule : disk_error_flag_and_seek_rules_tb_top

//--- testbench/drive_model.sv
`timescale 1ns/1ps
module drive_model (
  input  wire logic        mclk_i,
  input  wire logic [5:0]  fault_i,
  input  wire logic [7:0]  noise_i,
  output logic       [15:0] status_o
);
  // Status word from the drive pins, low byte carries non-error noise
  always_ff @(posedge mclk_i) begin
    status_o <= {fault_i[5:4], 1'b0, fault_i[3:1], 1'b0, fault_i[0], noise_i};
  end
endmodule : drive_model
